//--- serial_pkg.sv
package serial_pkg;

	// ---------------------------------------------------------------
	// Clock and shift clock timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned SCK_HALF_NS = 16;
	// Least half period, rounded up to whole system clocks
	localparam int unsigned SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_CONTROL = 4'h4;
	localparam logic [3:0] ADDR_DATA = 4'h8;

	// Status and control field positions
	localparam int unsigned BIT_ENABLE = 15;
	localparam int unsigned BIT_STOP_IDLE = 13;
	localparam int unsigned BIT_OVERFLOW = 6;
	localparam int unsigned BIT_TX_FULL = 1;
	localparam int unsigned BIT_RX_FULL = 0;

	// Link configuration field positions
	localparam int unsigned BIT_WORD_WIDTH_SELECT = 10;
	localparam int unsigned BIT_CKE = 8;
	localparam int unsigned BIT_CPOL = 6;
	localparam int unsigned BIT_MASTER = 5;

	// Reset values and word sizes
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [4:0] WORD_BITS = 5'h10;
	localparam logic [4:0] BYTE_BITS = 5'h08;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic enable;
		logic stop_idle;
		logic word_width_select;
		logic cke;
		logic cpol;
		logic master;
	} cfg_t;

	typedef struct packed {
		logic sck;
		logic sdi;
		logic ss_n;
	} link_in_t;

	typedef struct packed {
		logic sck;
		logic sck_oe_n;
		logic sdo;
		logic sdo_oe_n;
	} link_out_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01
	} engine_state_t;

endpackage : serial_pkg

//--- serial_port.sv
// What this block does
// - Data shifts through a 16-bit shift register, separate from the software buffer.
// - Link has four pins: data in, data out, shift clock, active-low select.
// - Master drives the shift clock; slave takes the shift clock from outside.
// - Enable bit 15 activates module and hands it the pins; clear disables.
// - Stop-in-idle bit 13 halts the module while the device idles.
// - Word arriving while receive buffer unread is discarded; overflow bit 6 set.
// - Write to buffer address loads transmit holding buffer, sets bit 1.
// - Transmit-full clears when the held word moves into the shift register; here bit 1 clears only once the FIFO is empty.
// - Completed reception copies shift register to receive buffer, sets bit 0.
// - Reading the buffer address returns received data and clears bit 0.
// - Bits 14, 12 to 7 and 5 to 2 of status read zero.
// - Word-width select picks 16-bit transfers when set, 8-bit when clear.
// - Clock polarity set makes idle clock high; clear makes it low.
// - Edge select set changes output on active-to-idle, else idle-to-active.
// - Master select set gives master mode, clear gives slave mode.
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns

// ---------------------------------------------------------------
// Transmit FIFO
// ---------------------------------------------------------------
module serial_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("serial_fifo depth must be a power of two");
	end

	// Honest flags straight from the fill count
	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Pointers and fill count
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end

endmodule : serial_fifo

// ---------------------------------------------------------------
// Serial port top
// ---------------------------------------------------------------
module serial_port #(
	parameter int unsigned SCK_HALF = serial_pkg::SCK_HALF_CYC,
	parameter int unsigned FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Device power state, same clock domain
	input wire logic cpu_idle,
	// Serial link pins
	input wire serial_pkg::link_in_t link_in,
	output serial_pkg::link_out_t link_out
);
	import serial_pkg::*;

	initial
	begin
		if (SCK_HALF < 1 || SCK_HALF > 65535)
			$error("serial_port shift clock half period out of range");
	end

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	cfg_t cfg;
	engine_state_t state;
	logic [1:0] sck_sync;
	logic [1:0] sdi_sync;
	logic [1:0] ss_sync;
	logic sck_last;
	logic overflow;
	logic rx_full;
	logic [15:0] rx_holding_buffer;
	logic [15:0] shift_register;
	logic [4:0] bit_cnt;
	logic [5:0] edge_cnt;
	logic [15:0] div_cnt;
	logic rx_done;
	logic rd_saw_full;
	logic access;
	logic data_wr;
	logic data_rd;
	logic tx_push;
	logic tx_ready;
	logic tx_valid;
	logic tx_pop;
	logic [15:0] tx_holding_buffer;
	logic halted;
	logic tick;
	logic lead;
	logic trail;
	logic sample_edge;
	logic out_edge;
	logic [4:0] word_bits;
	logic [15:0] status_word;
	logic [15:0] control_word;
	logic [15:0] next_shift;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Two flops per pin; only the second stage is read below
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			sck_sync <= 2'h0;
			sdi_sync <= 2'h0;
			ss_sync <= 2'h3;
			sck_last <= 1'b0;
		end
		else
		begin
			sck_sync <= {sck_sync[0], link_in.sck};
			sdi_sync <= {sdi_sync[0], link_in.sdi};
			ss_sync <= {ss_sync[0], link_in.ss_n};
			sck_last <= sck_sync[1];
		end
	end

	// ---------------------------------------------------------------
	// Avalon slave
	// ---------------------------------------------------------------
	// A data write stalls while the FIFO is full, so back-pressure reaches software
	assign data_wr = write && (address == ADDR_DATA);
	assign data_rd = read && (address == ADDR_DATA);
	assign access = (read || write) && !waitrequest;
	assign tx_push = access && data_wr && byteenable[0];

	// One wait cycle per access, more while a data write finds the FIFO full; answer at the edge after waitrequest drops
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			waitrequest <= 1'b1;
		else if ((read || write) && waitrequest && !(data_wr && !tx_ready))
			waitrequest <= 1'b0;
		else
			waitrequest <= 1'b1;
	end

	// Status image; unused bits stay zero
	always_comb
	begin
		status_word = STATUS_RESET;
		status_word[BIT_ENABLE] = cfg.enable;
		status_word[BIT_STOP_IDLE] = cfg.stop_idle;
		status_word[BIT_OVERFLOW] = overflow;
		status_word[BIT_TX_FULL] = tx_valid;
		status_word[BIT_RX_FULL] = rx_full;
		control_word = CONTROL_RESET;
		control_word[BIT_WORD_WIDTH_SELECT] = cfg.word_width_select;
		control_word[BIT_CKE] = cfg.cke;
		control_word[BIT_CPOL] = cfg.cpol;
		control_word[BIT_MASTER] = cfg.master;
	end

	// Read data captured in the wait cycle and held to the answer edge
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			readdata <= 32'h0;
			rd_saw_full <= 1'b0;
		end
		else if (read && waitrequest)
		begin
			unique case (address)
				ADDR_STATUS: readdata <= {16'h0, status_word};
				ADDR_CONTROL: readdata <= {16'h0, control_word};
				ADDR_DATA: readdata <= {16'h0, rx_holding_buffer};
				default: readdata <= 32'h0;
			endcase
			rd_saw_full <= data_rd && rx_full;
		end
	end

	// Software-written configuration
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			cfg <= '0;
		else if (access && write)
		begin
			if (address == ADDR_STATUS && byteenable[1])
			begin
				cfg.enable <= writedata[BIT_ENABLE];
				cfg.stop_idle <= writedata[BIT_STOP_IDLE];
			end
			if (address == ADDR_CONTROL && byteenable[1])
			begin
				cfg.word_width_select <= writedata[BIT_WORD_WIDTH_SELECT];
				cfg.cke <= writedata[BIT_CKE];
			end
			if (address == ADDR_CONTROL && byteenable[0])
			begin
				cfg.cpol <= writedata[BIT_CPOL];
				cfg.master <= writedata[BIT_MASTER];
			end
		end
	end

	// ---------------------------------------------------------------
	// Transmit holding path
	// ---------------------------------------------------------------
	// FIFO head is the transmit holding buffer; full flag means it holds a word
	serial_fifo #(
		.WIDTH(16),
		.DEPTH(FIFO_DEPTH)
	) tx_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(tx_push),
		.in_ready(tx_ready),
		.in_data(writedata[15:0]),
		.out_valid(tx_valid),
		.out_ready(tx_pop),
		.out_data(tx_holding_buffer)
	);

	// ---------------------------------------------------------------
	// Shift engine
	// ---------------------------------------------------------------
	assign halted = !cfg.enable || (cfg.stop_idle && cpu_idle);
	assign word_bits = cfg.word_width_select ? WORD_BITS : BYTE_BITS;
	assign tick = (state == ST_RUN) && cfg.master && !halted && (div_cnt == 16'(SCK_HALF - 1));

	// Edge finder: master from its own divider, slave from the synced pin
	always_comb
	begin
		if (cfg.master)
		begin
			lead = tick && (link_out.sck == cfg.cpol);
			trail = tick && (link_out.sck != cfg.cpol);
		end
		else
		begin
			lead = (state == ST_RUN) && !halted && !ss_sync[1] && (sck_sync[1] != sck_last)
				&& (sck_sync[1] != cfg.cpol);
			trail = (state == ST_RUN) && !halted && !ss_sync[1] && (sck_sync[1] != sck_last)
				&& (sck_sync[1] == cfg.cpol);
		end
		sample_edge = cfg.cke ? lead : trail;
		out_edge = cfg.cke ? trail : lead;
		next_shift = {shift_register[14:0], sdi_sync[1]};
	end

	// Load a word when idle: master needs a held word, slave needs select low
	assign tx_pop = (state == ST_IDLE) && !halted && tx_valid
		&& (cfg.master || !ss_sync[1]);

	// Sequencer, shift register and pin drive
	always_ff @(posedge sys_clk)
	begin
		if (rst || !cfg.enable)
		begin
			state <= ST_IDLE;
			shift_register <= 16'h0;
			bit_cnt <= 5'h0;
			edge_cnt <= 6'h0;
			div_cnt <= 16'h0;
			rx_done <= 1'b0;
			link_out <= '{sck: cfg.cpol && !rst, sck_oe_n: 1'b1, sdo: 1'b0, sdo_oe_n: 1'b1};
		end
		else
		begin
			rx_done <= 1'b0;
			link_out.sck_oe_n <= !cfg.master;
			link_out.sdo_oe_n <= !(cfg.master || !ss_sync[1]);
			unique case (state)
				ST_IDLE:
				begin
					div_cnt <= 16'h0;
					bit_cnt <= 5'h0;
					edge_cnt <= 6'h0;
					if (cfg.master)
						link_out.sck <= cfg.cpol;
					if (!halted && (cfg.master ? tx_valid : !ss_sync[1]))
					begin
						// Slave with nothing held shifts out zeros, except a stale first bit from tx_holding_buffer when edge select is set
						shift_register <= tx_valid ? tx_holding_buffer : 16'h0;
						state <= ST_RUN;
						if (cfg.cke)
							link_out.sdo <= cfg.word_width_select ? tx_holding_buffer[15] : tx_holding_buffer[7];
					end
				end
				ST_RUN:
				begin
					if (!cfg.master && ss_sync[1])
						state <= ST_IDLE; // Select dropped mid-word: partial word lost
					if (cfg.master && !halted)
						div_cnt <= tick ? 16'h0 : div_cnt + 16'h1;
					if (tick)
					begin
						link_out.sck <= !link_out.sck;
						edge_cnt <= edge_cnt + 6'h1;
						if (edge_cnt == {word_bits, 1'b0} - 6'h1)
							state <= ST_IDLE;
					end
					if (out_edge)
						link_out.sdo <= cfg.word_width_select ? shift_register[15] : shift_register[7];
					if (sample_edge)
					begin
						shift_register <= next_shift;
						bit_cnt <= bit_cnt + 5'h1;
						if (bit_cnt == word_bits - 5'h1)
						begin
							rx_done <= 1'b1;
							if (!cfg.master)
								state <= ST_IDLE;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Receive holding path
	// ---------------------------------------------------------------
	// Clear only when the returned data was the full buffer; a word arriving in the clearing cycle is discarded
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rx_full <= 1'b0;
			rx_holding_buffer <= 16'h0;
		end
		else if (rx_done && !rx_full)
		begin
			rx_holding_buffer <= cfg.word_width_select ? shift_register : {8'h0, shift_register[7:0]};
			rx_full <= 1'b1;
		end
		else if (access && data_rd && rd_saw_full)
			rx_full <= 1'b0;
	end

	// Overflow: set wins over a software clear in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			overflow <= 1'b0;
		else if (rx_done && rx_full)
			overflow <= 1'b1;
		else if (access && write && address == ADDR_STATUS && byteenable[0]
			&& !writedata[BIT_OVERFLOW])
			overflow <= 1'b0;
	end

endmodule : serial_port

//--- serial_port_chk.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Link and register checker
// ---------------------------------------------------------------
module serial_port_chk
	import serial_pkg::*;
#(
	parameter int unsigned SCK_HALF = 4,
	parameter int unsigned FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register bus
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Power state and pins
	input wire logic cpu_idle,
	input wire serial_pkg::link_in_t link_in,
	input wire serial_pkg::link_out_t link_out
);
	logic en, stop, m16, cke, cpol, mst, drv, halt, wr_ok, prev_sck;
	int unsigned gap, ntog;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	assign wr_ok = write && !waitrequest;
	assign drv = en && mst;
	// A disabled module follows polarity writes, so only an enabled one counts as halted
	assign halt = en && stop && cpu_idle;
	// Settings shadow, taken at the completing edge of a write
	always_ff @(posedge sys_clk)
		if (rst)
			{en, stop, m16, cke, cpol, mst} <= '0;
		else if (wr_ok && address == ADDR_STATUS)
			{en, stop} <= {writedata[BIT_ENABLE], writedata[BIT_STOP_IDLE]};
		else if (wr_ok && address == ADDR_CONTROL)
			{m16, cke, cpol, mst} <= {writedata[10], writedata[8], writedata[6], writedata[5]};
	// Driven clock toggles per burst; a gap of a half period ends a word
	always_ff @(posedge sys_clk)
		if (rst)
		begin
			prev_sck <= 1'h0;
			gap <= 0;
			ntog <= 0;
		end
		else
		begin
			prev_sck <= link_out.sck;
			if (link_out.sck != prev_sck && !link_out.sck_oe_n)
			begin
				gap <= 0;
				// Back-to-back words: a full half-period pause starts a new count
				ntog <= (gap >= SCK_HALF) ? 1 : ntog + 1;
			end
			else if (gap <= SCK_HALF)
				gap <= gap + 1;
			else
				ntog <= 0;
		end
	sequence s_stat_rd;
		read && waitrequest && address == ADDR_STATUS ##1 !waitrequest;
	endsequence
	sequence s_halted;
		halt [*3];
	endsequence
	AST_STATUS_RSVD: assert property (s_stat_rd |-> (readdata & 32'hffff5fbc) == 0)
		else $error("reserved status bits not zero");
	AST_SCK_OWNER: assert property (!link_out.sck_oe_n |-> $past(drv))
		else $error("shift clock driven outside enabled master");
	AST_SCK_DRIVE: assert property (drv && $past(drv) |-> !link_out.sck_oe_n)
		else $error("enabled master leaves shift clock undriven");
	AST_PINS_OFF: assert property (!en && !$past(en) |-> link_out.sck_oe_n && link_out.sdo_oe_n)
		else $error("disabled module holds a pin");
	AST_IDLE_LEVEL: assert property (!en && !$past(en) && $stable(cpol) |-> link_out.sck == cpol)
		else $error("idle clock level differs from polarity");
	AST_WORD_EDGES: assert property (gap == SCK_HALF && ntog != 0 |-> ntog == (m16 ? 32 : 16))
		else $error("wrong number of clock edges in a word");
	AST_HALT: assert property (s_halted |-> $stable(link_out.sck))
		else $error("clock moves while halted in idle");
	AST_SDO_EDGE: assert property ($changed(link_out.sdo) && !link_out.sck_oe_n && !$past(link_out.sck_oe_n)
		|-> ($changed(link_out.sck) ? ((link_out.sck != cpol) != cke) : cke))
		else $error("data out changed on the wrong clock edge");
endmodule : serial_port_chk

bind serial_port serial_port_chk #(.SCK_HALF(SCK_HALF), .FIFO_DEPTH(FIFO_DEPTH)) serial_port_chk_i (
	.sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
	.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
	.waitrequest(waitrequest), .cpu_idle(cpu_idle), .link_in(link_in), .link_out(link_out));

//--- serial_peer.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Far-side serial peer
// ---------------------------------------------------------------
module serial_peer (
	// Wire side
	input wire logic sck_w,
	input wire logic sdo_w,
	output logic sdi,
	output logic sck_o,
	output logic ss_n,
	// Bench side
	input wire logic cpol,
	input wire logic cke,
	input wire logic [4:0] nbits,
	input wire logic [15:0] reply,
	input wire logic drive,
	input wire logic clr,
	output logic [15:0] rx_word,
	output logic rx_valid
);
	logic [15:0] tx;
	int cnt = 0;
	int nw = 0;
	initial
	begin
		{sdi, sck_o, ss_n, rx_valid} = 4'h2;
		{tx, rx_word} = 32'h0;
	end
	// Sends on lead edges with edge select low, on trail edges with it high;
	// takes on the other edge; reply grows by one per word
	always @(sck_w)
	begin
		if ((sck_w !== cpol) != cke)
		begin
			if (cnt == 0 && !cke)
				tx = 16'((reply + nw) << (16 - nbits));
			// Late-edge mode preloads the first bit, so nothing moves between words
			if (cnt != 0 || !cke)
			begin
				sdi = tx[15];
				tx = tx << 1;
			end
		end
		else
		begin
			rx_word = {(cnt == 0) ? 15'h0 : rx_word[14:0], sdo_w};
			cnt++;
			if (cnt == nbits)
			begin
				cnt = 0;
				nw++;
				if (cke)
				begin
					tx = 16'((reply + nw) << (16 - nbits));
					sdi = tx[15];
					tx = tx << 1;
				end
				rx_valid = 1'h1;
				#1 rx_valid = 1'h0;
			end
		end
	end
	// Master role for slave mode; the clock stands still between frames
	always @(posedge drive)
	begin
		ss_n = 1'h0;
		#64;
		repeat (2 * nbits)
		begin
			#32;
			sck_o = ~sck_o;
		end
		#64;
		ss_n = 1'h1;
	end
	// Realign after configuration glitches on the clock wire
	always @(posedge clr)
	begin
		cnt = 0;
		nw = 0;
		tx = 16'(reply << (16 - nbits));
		sdi = tx[15];
		tx = tx << 1;
	end
endmodule : serial_peer

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import serial_pkg::*;
	// ---------------------------------------------------------------
	// Bench signals
	// ---------------------------------------------------------------
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic [3:0] address = 4'h0;
	logic read = 1'h0;
	logic write = 1'h0;
	logic [31:0] writedata = 32'h0;
	logic cpu_idle = 1'h0;
	logic cpol = 1'h0;
	logic cke = 1'h0;
	logic drive = 1'h0;
	logic clr = 1'h0;
	logic done = 1'h0;
	logic [4:0] nbits = 5'h10;
	logic [15:0] reply = 16'h0;
	logic [31:0] seed = 32'h1333;
	logic [31:0] readdata, q;
	logic waitrequest, sck_w, sdo_w, p_sck, p_ss_n, p_sdi, rx_valid;
	logic [15:0] rx_word;
	logic [15:0] exp_q[$];
	link_in_t link_in;
	link_out_t link_out;
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;
	always #2 sys_clk = ~sys_clk;
	// Wire levels; released data out shows the inverse of its last value
	assign sck_w = link_out.sck_oe_n ? p_sck : link_out.sck;
	assign sdo_w = link_out.sdo_oe_n ? ~link_out.sdo : link_out.sdo;
	assign link_in = {sck_w, p_sdi, p_ss_n};
	serial_port #(.SCK_HALF(4), .FIFO_DEPTH(8)) serial_port_i (.sys_clk(sys_clk), .rst(rst),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
		.cpu_idle(cpu_idle), .link_in(link_in), .link_out(link_out));
	serial_peer serial_peer_i (.sck_w(sck_w), .sdo_w(sdo_w), .sdi(p_sdi), .sck_o(p_sck),
		.ss_n(p_ss_n), .cpol(cpol), .cke(cke), .nbits(nbits), .reply(reply), .drive(drive),
		.clr(clr), .rx_word(rx_word), .rx_valid(rx_valid));
	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	function automatic logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction : rnd
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want)
		begin
			mismatches++;
			$display("mismatch at %0t: saw %h, wanted %h", $time, seen, want);
		end
	endtask : check
	// Holds the request until waitrequest is seen low; an edge passes after release
	task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
		int t;
		t = 0;
		address <= a;
		writedata <= {16'h0, d};
		read <= !wr;
		write <= wr;
		@(posedge sys_clk);
		while (waitrequest !== 1'h0 && t < 3000)
		begin
			@(posedge sys_clk);
			t++;
		end
		q = readdata;
		read <= 1'h0;
		write <= 1'h0;
		if (t == 3000)
			mismatches++;
		@(posedge sys_clk);
	endtask : bus
	task automatic rdchk(input logic [3:0] a, input logic [31:0] want);
		bus(1'h0, a, 16'h0);
		check(q, want);
	endtask : rdchk
	// Always reads afresh, so a stale word left in q never ends the wait
	task automatic poll(input int b, input logic v);
		bus(1'h0, ADDR_STATUS, 16'h0);
		repeat (400)
			if (q[b] !== v || q[31:16] !== 16'h0)
				bus(1'h0, ADDR_STATUS, 16'h0);
		check(q[b], v);
	endtask : poll
	task automatic send(input logic [15:0] d);
		exp_q.push_back(nbits == WORD_BITS ? d : {8'h0, d[7:0]});
		bus(1'h1, ADDR_DATA, d);
	endtask : send
	// Disable, control, then status, so no setting changes under a driven clock;
	// then the peer is realigned
	task automatic cfg(input logic [15:0] ctl, input logic [15:0] st);
		bus(1'h1, ADDR_STATUS, 16'h0);
		bus(1'h1, ADDR_CONTROL, ctl);
		bus(1'h1, ADDR_STATUS, st);
		repeat (3) @(posedge sys_clk);
		cpol <= ctl[BIT_CPOL];
		cke <= ctl[BIT_CKE];
		nbits <= ctl[BIT_WORD_WIDTH_SELECT] ? WORD_BITS : BYTE_BITS;
		clr <= 1'h1;
		@(posedge sys_clk);
		clr <= 1'h0;
		q = 32'hffffffff;
	endtask : cfg
	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	// Words taken by the peer, in the order they were written
	always @(posedge rx_valid)
		if (exp_q.size() != 0)
			check({16'h0, rx_word}, {16'h0, exp_q.pop_front()});
		else
			check(32'h1, 32'h0);
	// Hang guard, far above the expected run length
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			give_verdict();
		end
	end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'h0;
		@(posedge sys_clk);
		rdchk(ADDR_STATUS, {16'h0, STATUS_RESET});
		rdchk(ADDR_CONTROL, {16'h0, CONTROL_RESET});
		bus(1'h1, 4'hc, 16'hffff);
		rdchk(4'hc, 32'h0);
		bus(1'h1, ADDR_STATUS, 16'h7fff);
		rdchk(ADDR_STATUS, 32'h2000);
		bus(1'h1, ADDR_CONTROL, 16'hffff);
		rdchk(ADDR_CONTROL, 32'h0560);
		// Halted in idle: the word waits with the buffer full
		cpu_idle <= 1'h1;
		reply <= rnd();
		cfg(16'h0420, 16'ha000);
		send(rnd());
		rdchk(ADDR_STATUS, 32'ha002);
		repeat (100) @(posedge sys_clk);
		rdchk(ADDR_STATUS, 32'ha002);
		cpu_idle <= 1'h0;
		poll(BIT_TX_FULL, 1'h0);
		poll(BIT_RX_FULL, 1'h1);
		rdchk(ADDR_DATA, {16'h0, reply});
		rdchk(ADDR_STATUS, 32'ha000);
		// Fill until refused, then back-to-back words overrun receive
		cpu_idle <= 1'h1;
		repeat (8) send(rnd());
		fork
			begin
				send(rnd());
				done = 1'h1;
			end
			begin
				repeat (40) @(posedge sys_clk);
				check(done, 1'h0);
				cpu_idle <= 1'h0;
			end
		join
		repeat (3000)
			if (exp_q.size() != 0)
				@(posedge sys_clk);
		poll(BIT_TX_FULL, 1'h0);
		rdchk(ADDR_DATA, {16'h0, reply + 16'h1});
		rdchk(ADDR_STATUS, 32'ha040);
		bus(1'h1, ADDR_STATUS, 16'ha000);
		rdchk(ADDR_STATUS, 32'ha000);
		// Byte words with a high idle clock
		cfg(16'h0060, 16'h8000);
		send(rnd());
		poll(BIT_RX_FULL, 1'h1);
		rdchk(ADDR_DATA, {24'h0, reply[7:0]});
		check(link_out.sck, 1'h1);
		// Slave mode: the peer clocks a word each way
		cfg(16'h0400, 16'h8000);
		check(link_out.sck_oe_n, 1'h1);
		send(rnd());
		drive <= 1'h1;
		@(posedge sys_clk);
		drive <= 1'h0;
		poll(BIT_RX_FULL, 1'h1);
		rdchk(ADDR_DATA, {16'h0, reply});
		// Edge select set: data out moves on the return to idle
		reply <= rnd();
		cfg(16'h0520, 16'h8000);
		send(rnd());
		poll(BIT_RX_FULL, 1'h1);
		rdchk(ADDR_DATA, {16'h0, reply});
		give_verdict();
	end
endmodule : tb_top
